// ==== hw/nsz_exec.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "nsz_defs.svh"
module nsz_exec
    import nsz_pkg::*;
#(
    // operand geometry
    parameter int DATA_W = `NSZ_DATA_W,
    parameter int NIB_W = `NSZ_NIB_W,
    parameter int BIT_W = `NSZ_BIT_W
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // decoded instruction with operand byte
    input wire nsz_req_type req,
    output logic busy,
    // write-back to memory and accumulator
    output nsz_wr_type wr,
    // skip control toward program counter
    output logic skip,
    output logic dummy,
    output logic done,
    // status flags kept unchanged
    output logic flags_we
);
    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (DATA_W != $bits(req.mem_data))
    begin : g_bad_data_w
        $error("data width must match the operand byte");
    end
    if (NIB_W * 2 != DATA_W)
    begin : g_bad_nib_w
        $error("nibble width must be half the data width");
    end
    if (2 ** BIT_W != DATA_W)
    begin : g_bad_bit_w
        $error("bit index width must reach every data bit");
    end

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_DUMMY} nsz_state_type;
    nsz_state_type state_r;
    nsz_state_type state_nxt;
    nsz_wr_type wr_r;
    nsz_wr_type wr_nxt;
    logic skip_r;
    logic done_r;

    wire logic take = req.valid && state_r == ST_IDLE;
    wire logic [DATA_W-1:0] swapped = {req.mem_data[NIB_W-1:0], req.mem_data[DATA_W-1:NIB_W]}; // RULE1 RULE2
    wire logic byte_zero = req.mem_data == 8'h00; // RULE4 RULE6
    wire logic [DATA_W-1:0] bit_low;
    for (genvar gi = 0; gi < DATA_W; gi++)
    begin : g_bit_sel
        assign bit_low[gi] = req.bit_sel == BIT_W'(gi) && !req.mem_data[gi]; // RULE8
    end
    wire logic bit_zero = |bit_low; // RULE7
    wire logic is_swap = req.op == NSZ_OP_SWAP;
    wire logic is_swapa = req.op == NSZ_OP_SWAPA;
    wire logic is_sz = req.op == NSZ_OP_SZ;
    wire logic is_sza = req.op == NSZ_OP_SZA;
    wire logic is_szb = req.op == NSZ_OP_SZBIT;
    wire logic want_skip = ((is_sz || is_sza) && byte_zero) || (is_szb && bit_zero); // RULE4 RULE6 RULE7

    always_comb
    begin
        wr_nxt = '0;
        if (take)
        begin
            wr_nxt.mem_we = is_swap || is_sz; // RULE1 RULE4
            wr_nxt.mem_wdata = is_swap ? swapped : req.mem_data; // RULE1 RULE4
            wr_nxt.acc_we = is_swapa || is_sza; // RULE2 RULE6
            wr_nxt.acc_wdata = is_swapa ? swapped : req.mem_data; // RULE2 RULE6
        end
    end

    // ------------------------------------------------------------
    // skip sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (take && want_skip) state_nxt = ST_FETCH; // RULE5
            ST_FETCH: state_nxt = ST_DUMMY;
            ST_DUMMY: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    wire logic is_none = req.op == NSZ_OP_NONE;
    wire logic skip_nxt = take && want_skip; // RULE4 RULE6 RULE7
    wire logic done_nxt = (take && !want_skip && !is_none) || state_r == ST_DUMMY; // RULE5

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            state_r <= ST_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            wr_r <= '0;
        end
        else
        begin
            wr_r <= wr_nxt;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            skip_r <= 1'h0;
            done_r <= 1'h0;
        end
        else
        begin
            skip_r <= skip_nxt;
            done_r <= done_nxt;
        end
    end

    assign wr = wr_r;
    assign skip = skip_r;
    assign dummy = state_r == ST_DUMMY; // RULE5
    assign busy = state_r != ST_IDLE;
    assign done = done_r;
    assign flags_we = 1'h0; // RULE3

    // ------------------------------------------------------------
    // instruction cycle count
    // ------------------------------------------------------------
    logic [1:0] cyc_r;
    logic [1:0] cyc_nxt;
    wire logic cyc_start = take && !is_none;

    always_comb
    begin
        cyc_nxt = 2'h0;
        if (cyc_start)
        begin
            cyc_nxt = 2'h1;
        end
        else if (busy)
        begin
            cyc_nxt = cyc_r + 2'h1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            cyc_r <= 2'h0;
        end
        else
        begin
            cyc_r <= cyc_nxt;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_swap_inplace: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE1
        take && is_swap |=> wr.mem_we && wr.mem_wdata == {$past(req.mem_data[3:0]), $past(req.mem_data[7:4])})
        else $error("in-place swap wrong");
    a_swap_acc: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE2
        take && is_swapa |=> !wr.mem_we && wr.acc_we && wr.acc_wdata[3:0] == $past(req.mem_data[7:4])
            && wr.acc_wdata[7:4] == $past(req.mem_data[3:0]))
        else $error("swap to acc wrong");
    a_flags_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE3
        !flags_we) else $error("flags written");
    a_byte_rewrite: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE4
        take && is_sz |=> wr.mem_we && wr.mem_wdata == $past(req.mem_data) && !wr.acc_we
            && skip == ($past(req.mem_data) == 8'h00))
        else $error("byte test wrong");
    a_skip_three: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
        take && want_skip |=> busy ##1 dummy ##1 done && !busy) else $error("skip not three cycles");
    a_copy_acc: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE6
        take && is_sza |=> wr.acc_we && wr.acc_wdata == $past(req.mem_data) && !wr.mem_we)
        else $error("copy test wrong");
    a_bit_test: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE7
        take && is_szb |=> !wr.mem_we && !wr.acc_we && skip == !$past(req.mem_data[req.bit_sel]))
        else $error("bit test wrong");
    a_noskip_one: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
        take && !want_skip && is_swap |=> done && !busy) else $error("plain op not single cycle");
    a_skip_cycles: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
        done && $past(dummy) |-> cyc_r == 2'(`NSZ_SKIP_CYC))
        else $error("skip instruction cycle count wrong");
    a_plain_cycles: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
        done && !$past(dummy) |-> cyc_r == 2'(`NSZ_PLAIN_CYC))
        else $error("plain instruction cycle count wrong");
    a_busy_refuse: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
        busy && req.valid |=> !wr.mem_we && !wr.acc_we && !skip)
        else $error("request taken while busy");
    a_skip_dummy: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
        skip |-> busy && !dummy ##1 dummy && !skip)
        else $error("dummy slot misplaced");
    a_reset_quiet: assert property (@(posedge sys_clk) // RULE5
        !resetn |=> !busy && !dummy && !skip && !done && wr == '0)
        else $error("outputs active after reset");
    a_one_target: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE2
        !(wr.mem_we && wr.acc_we))
        else $error("memory and accumulator written together");
    a_none_quiet: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE3
        take && is_none |=> wr == '0 && !skip && !done)
        else $error("empty slot had an effect");
endmodule
`default_nettype wire

// ==== hw/nsz_defs.svh ====
// Notes on behaviour
// RULE1: in-place swap exchanges byte nibbles and writes result to same address.
// RULE2: swap-to-acc loads swapped nibbles into accumulator, memory stays unmodified.
// RULE3: none of these instructions changes any status flag.
// RULE4: byte test rewrites same value, skips next instruction when byte is zero.
// RULE5: a taken skip inserts a dummy cycle, instruction takes three cycles.
// RULE6: copy test loads byte into accumulator, skips when byte is zero.
// RULE7: bit test skips when selected bit is zero, memory and flags untouched.
// RULE8: bit index is a 3-bit field selecting bit 0 to 7.
`ifndef NSZ_DEFS_SVH
`define NSZ_DEFS_SVH
`define NSZ_DATA_W 8
`define NSZ_NIB_W 4
`define NSZ_BIT_W 3
`define NSZ_SKIP_CYC 3
`define NSZ_PLAIN_CYC 1
`endif

// ==== hw/nsz_pkg.sv ====
package nsz_pkg;
    typedef enum logic [2:0]
    {
        NSZ_OP_NONE,
        NSZ_OP_SWAP,
        NSZ_OP_SWAPA,
        NSZ_OP_SZ,
        NSZ_OP_SZA,
        NSZ_OP_SZBIT
    } nsz_op_type;

    typedef struct packed
    {
        logic valid;
        nsz_op_type op;
        logic [2:0] bit_sel;
        logic [7:0] mem_data;
    } nsz_req_type;

    typedef struct packed
    {
        logic mem_we;
        logic [7:0] mem_wdata;
        logic acc_we;
        logic [7:0] acc_wdata;
    } nsz_wr_type;
endpackage

// ==== testbench/tb_nibble_swap_skip_zero_exec.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_nibble_swap_skip_zero_exec
    import nsz_pkg::*;
;
    logic sys_clk = 1'h0;
    logic resetn = 1'h0;
    logic busy, skip, dummy, done, flags_we;
    nsz_req_type req = '0;
    nsz_wr_type wr;
    int n_errors = 0;
    int n_tests = 0;
    always #5 sys_clk = ~sys_clk;
    nsz_exec nsz_exec_inst (.sys_clk(sys_clk), .resetn(resetn), .req(req), .busy(busy), .wr(wr),
        .skip(skip), .dummy(dummy), .done(done), .flags_we(flags_we));
    task complete_run();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // issue one request, check the write-back and the skip sequence
    task run(input nsz_op_type op, input logic [2:0] b, input logic [7:0] d, input logic [17:0] w, input logic sk);
        logic [17:0] m;
        m = {1'h1, {8{w[17]}}, 1'h1, {8{w[8]}}};
        req = {1'h1, op, b, d};
        @(negedge sys_clk);
        req.valid = 1'h0;
        chk("wr", wr & m, w);
        chk("skip", skip, sk);
        chk("done", done, !sk);
        chk("busy", busy, sk);
        chk("dummy", dummy, 18'h0);
        chk("flags_we", flags_we, 18'h0);
        if (sk)
        begin
            @(negedge sys_clk);
            chk("dummy", dummy, 18'h1);
            chk("busy", busy, 18'h1);
            @(negedge sys_clk);
            chk("done", done, 18'h1);
            chk("busy", busy, 18'h0);
        end
        @(negedge sys_clk);
        chk("wr", wr, 18'h0);
    endtask
    task t_swap();
        run(NSZ_OP_SWAP, 0, 8'hA5, {1'b1, 8'h5A, 9'h0}, 0);
        run(NSZ_OP_SWAPA, 0, 8'h3C, {9'h0, 1'b1, 8'hC3}, 0);
    endtask
    task t_sz();
        run(NSZ_OP_SZ, 0, 8'h00, {1'b1, 8'h00, 9'h0}, 1);
        run(NSZ_OP_SZ, 0, 8'h80, {1'b1, 8'h80, 9'h0}, 0);
        run(NSZ_OP_SZA, 0, 8'h00, {9'h0, 1'b1, 8'h00}, 1);
        run(NSZ_OP_SZA, 0, 8'h01, {9'h0, 1'b1, 8'h01}, 0);
    endtask
    task t_bit();
        for (int i = 0; i < 8; i++)
        begin
            run(NSZ_OP_SZBIT, i[2:0], ~(8'h01 << i), 18'h0, 1);
            run(NSZ_OP_SZBIT, i[2:0], 8'h01 << i, 18'h0, 0);
        end
    endtask
    // a request held while the skip sequence runs is ignored
    task t_refuse();
        req = {1'h1, NSZ_OP_SZ, 3'h0, 8'h00};
        @(negedge sys_clk);
        req = {1'h1, NSZ_OP_SWAP, 3'h0, 8'h12};
        chk("skip", skip, 18'h1);
        @(negedge sys_clk);
        chk("wr", wr, 18'h0);
        chk("dummy", dummy, 18'h1);
        @(negedge sys_clk);
        req.valid = 1'h0;
        chk("wr", wr, 18'h0);
        chk("skip", skip, 18'h0);
        chk("done", done, 18'h1);
        @(negedge sys_clk);
    endtask
    // an empty slot has no effect
    task t_none();
        req = {1'h1, NSZ_OP_NONE, 3'h0, 8'h00};
        @(negedge sys_clk);
        req.valid = 1'h0;
        chk("wr", wr, 18'h0);
        chk("skip", skip, 18'h0);
        chk("done", done, 18'h0);
        @(negedge sys_clk);
    endtask
    // reset in the middle of a skip clears the sequence
    task t_reset();
        req = {1'h1, NSZ_OP_SZA, 3'h0, 8'h00};
        @(negedge sys_clk);
        req.valid = 1'h0;
        resetn = 1'h0;
        chk("busy", busy, 18'h1);
        @(negedge sys_clk);
        chk("busy", busy, 18'h0);
        chk("dummy", dummy, 18'h0);
        chk("wr", wr, 18'h0);
        @(negedge sys_clk);
        resetn = 1'h1;
        chk("done", done, 18'h0);
        chk("skip", skip, 18'h0);
        @(negedge sys_clk);
        chk("done", done, 18'h0);
    endtask
    initial
    begin
        #20000;
        n_errors++;
        complete_run();
    end
    initial
    begin
        repeat (20) @(negedge sys_clk);
        resetn = 1;
        t_swap();
        t_sz();
        t_bit();
        t_refuse();
        t_none();
        t_reset();
        t_swap();
        complete_run();
    end
endmodule
`default_nettype wire
